/* rtl/crmc_pkg.sv */
// Purpose: Shared constants and types for the card reader mode control block
// Assumes: Byte-wide register port, 10 MHz core clock
// Notes: Event bit order is shared by enable, request and live status registers
package crmc_pkg;
   // Register offsets
   localparam logic [7:0] CRMC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CRMC_ADDR_CFG1 = 8'h01;
   localparam logic [7:0] CRMC_ADDR_CFG2 = 8'h02;
   localparam logic [7:0] CRMC_ADDR_CFG3 = 8'h03;
   localparam logic [7:0] CRMC_ADDR_IE_LO = 8'h04;
   localparam logic [7:0] CRMC_ADDR_IE_HI = 8'h05;
   localparam logic [7:0] CRMC_ADDR_IRQ_LO = 8'h10;
   localparam logic [7:0] CRMC_ADDR_IRQ_HI = 8'h11;
   localparam logic [7:0] CRMC_ADDR_STAT = 8'h12;
   // Reset values
   localparam logic [7:0] CRMC_CTRL_RESET = 8'h18;
   localparam logic [7:0] CRMC_ZERO_RESET = 8'h00;
   // Control register fields
   localparam int CRMC_CTRL_WAKE = 0;
   localparam int CRMC_CTRL_MODE_LSB = 1;
   localparam int CRMC_CTRL_SW1 = 3;
   localparam int CRMC_CTRL_SW2 = 4;
   localparam logic [7:0] CRMC_CTRL_WR_MASK = 8'h1f;
   // Configuration register 1 fields and register 2 clock source
   localparam int CRMC_CFG1_ACTHI = 0;
   localparam int CRMC_CFG1_PULSE = 1;
   localparam int CRMC_CLKSRC_W = 5;
   localparam logic [4:0] CRMC_CLKSRC_DEFAULT = 5'h00;
   // Event bit positions
   localparam int CRMC_EV_CARD = 0;
   localparam int CRMC_EV_BUSY = 1;
   localparam int CRMC_EV_VBUS = 2;
   localparam int CRMC_EV_VSD = 3;
   localparam int CRMC_EV_VTM = 4;
   localparam int CRMC_EV_SUSP = 5;
   localparam int CRMC_EV_FS = 6;
   localparam int CRMC_NUM_EV = 7;
   // Timing
   localparam int CRMC_CLK_HZ = 10_000_000;
   localparam int CRMC_IRQ_PULSE_MS = 10;
   localparam int CRMC_IRQ_PULSE_CYCLES = CRMC_IRQ_PULSE_MS * (CRMC_CLK_HZ / 1000);
   // Edges after release before the synchronised strap is trusted
   localparam int CRMC_STRAP_WAIT = 4;
   // Pin input count
   localparam int CRMC_NUM_PINS = 10;

   typedef enum logic [1:0] {
      CRMC_SLOT_NONE = 2'b00,
      CRMC_SLOT_ONE = 2'b01,
      CRMC_SLOT_TWO = 2'b10
   } crmc_slot_t;

   // Two-bit card reader field; both 00 and 11 mean inactive
   function automatic crmc_slot_t crmc_decode_slot(input logic [1:0] fld);
      case (fld)
         2'b01: crmc_decode_slot = CRMC_SLOT_ONE;
         2'b10: crmc_decode_slot = CRMC_SLOT_TWO;
         default: crmc_decode_slot = CRMC_SLOT_NONE;
      endcase
   endfunction : crmc_decode_slot
endpackage : crmc_pkg

/* rtl/crmc_pin_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to core_clk
// Notes: A change is taken once stages two and three agree
`timescale 1ns/100ps
module crmc_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic rst_sync_b,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } crmc_sync_t;

   crmc_sync_t st_ff;
   crmc_sync_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pin_in;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      // First stage is read by the second stage only
      for (int i = 0; i < WIDTH; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.q[i] = st_ff.s3[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_out = st_ff.q;
endmodule : crmc_pin_sync

/* rtl/crmc_top.sv */
// Purpose: Mode selection, slot switches, interrupt and busy logic
// Assumes: Serial register engine outside presents one-cycle read/write strobes
// Notes: Strap is read only once the pin synchroniser holds the real level
// What this block does
// - Simple control low mode pin means pass-through; high means reader on slot 1.
// - Simple control keeps interrupts off, default clock, error and busy outputs live.
// - Mode pin rising in simple control attaches slot 1 and drives busy low.
// - Busy output low exactly while card-reader mode is in effect, both schemes.
// - Slot switch bit writes act at once, asleep or in reader mode.
// - Slot attached to the reader ignores its switch bit; the other still obeys.
// - Reader field written while asleep only takes effect after waking.
// - Reader field 00 and 11 inactive, 01 slot 1, 10 slot 2, reset 00.
// - Control bit 0 is wake request, reset 0; asleep means pass-through.
// - Switch bits close switches when 1, reset 1; slot 1 has card-present line.
// - Shared pin is error output in simple control, interrupt in serial control.
// - Sources masked after reset; masked events still set request bits.
// - Reading a request register clears it; status shows live conditions.
// - Interrupt polarity selectable; hold until status read or fixed pulse.
// - Interrupt pin floats while the wake bit is 0.
// - Connection, suspend, bus power and supply changes raise enabled interrupts.
// - Card events only for the slot in reader mode, never in pass-through.
// - Simple control: error output low on reader or supply errors in reader mode, mode kept.
// - Busy flag reads 1 while busy output is low; its change is an event.
// - Configuration 1 zero bits mean hold-until-read and active-low interrupt.
// - Switching reader slot drops busy for a cycle then raises it again.
`timescale 1ns/100ps
module crmc_top
   import crmc_pkg::*;
#(
   parameter int unsigned IRQ_PULSE_CYCLES = CRMC_IRQ_PULSE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic scheme_sel_pin,
   input wire logic mode_pin,
   input wire logic usb_connected,
   input wire logic usb_suspended,
   input wire logic bus_power_sense,
   input wire logic card_supply,
   input wire logic transceiver_supply,
   input wire logic card_present_line,
   input wire logic card2_present,
   input wire logic reader_error,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_ff,
   output logic busy_n_ff,
   output logic err_irq_ff,
   output logic err_irq_oe_ff,
   output logic slot1_sw_ff,
   output logic slot2_sw_ff,
   output logic [1:0] reader_slot_ff,
   output logic logic_on_ff,
   output logic [4:0] clk_src_ff
);
   localparam int CW = $clog2(IRQ_PULSE_CYCLES + 1);

   typedef struct packed {
      logic strap_done;
      logic scheme_i2c;
      logic [2:0] strap_cnt;
      logic [7:0] ctrl;
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [7:0] cfg3;
      logic [7:0] ie_lo;
      logic [7:0] ie_hi;
      logic [CRMC_NUM_EV-1:0] irq_lo;
      logic [CRMC_NUM_EV-1:0] live_prev;
      crmc_slot_t slot;
      logic irq_hold;
      logic [CW-1:0] pulse_cnt;
      logic [7:0] rdata;
      logic busy_n;
      logic int_out;
      logic int_oe;
      logic sw1;
      logic sw2;
      logic [4:0] clk_src;
      logic logic_on;
   } crmc_state_t;

   logic rst_m_ff;
   logic rst_sync_b;
   logic [CRMC_NUM_PINS-1:0] pins_s;
   logic sel_s, mode_s, conn_s, susp_s, vbus_s, vsd_s, vtm_s, cp1_s, cp2_s, err_s;
   crmc_state_t st_ff;
   crmc_state_t nxt_st;
   crmc_slot_t slot_req;
   logic [CRMC_NUM_EV-1:0] live;
   logic [CRMC_NUM_EV-1:0] events;
   logic hit_irq_lo;
   logic hit_stat;

   // Reset released through two flops
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m_ff <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_m_ff <= 1'b1;
         rst_sync_b <= rst_m_ff;
      end
   end

   crmc_pin_sync #(.WIDTH(CRMC_NUM_PINS)) i_crmc_pin_sync (
      .core_clk(core_clk),
      .rst_sync_b(rst_sync_b),
      .pin_in({scheme_sel_pin, mode_pin, usb_connected, usb_suspended, bus_power_sense,
               card_supply, transceiver_supply, card_present_line, card2_present,
               reader_error}),
      .pin_out(pins_s)
   );
   assign {sel_s, mode_s, conn_s, susp_s, vbus_s, vsd_s, vtm_s, cp1_s, cp2_s, err_s} = pins_s;

   assign hit_irq_lo = reg_rd && (reg_addr == CRMC_ADDR_IRQ_LO);
   assign hit_stat = reg_rd && (reg_addr == CRMC_ADDR_STAT);

   always_comb begin
      nxt_st = st_ff;
      // Strap caught once the synchroniser has filled, then frozen
      if (!st_ff.strap_done) begin
         if (st_ff.strap_cnt == 3'(CRMC_STRAP_WAIT)) begin
            nxt_st.strap_done = 1'b1;
            nxt_st.scheme_i2c = sel_s;
         end else begin
            nxt_st.strap_cnt = st_ff.strap_cnt + 3'h1;
         end
      end
      // Register writes; reserved control bits forced to zero, other registers stored as written
      if (reg_wr) begin
         case (reg_addr)
            CRMC_ADDR_CTRL: nxt_st.ctrl = reg_wdata & CRMC_CTRL_WR_MASK;
            CRMC_ADDR_CFG1: nxt_st.cfg1 = reg_wdata;
            CRMC_ADDR_CFG2: nxt_st.cfg2 = reg_wdata;
            CRMC_ADDR_CFG3: nxt_st.cfg3 = reg_wdata;
            CRMC_ADDR_IE_LO: nxt_st.ie_lo = reg_wdata;
            CRMC_ADDR_IE_HI: nxt_st.ie_hi = reg_wdata;
            default: ;
         endcase
      end
      // Requested reader slot per scheme
      slot_req = CRMC_SLOT_NONE;
      if (st_ff.strap_done) begin
         if (!st_ff.scheme_i2c) begin
            slot_req = mode_s ? CRMC_SLOT_ONE : CRMC_SLOT_NONE;
         end else if (st_ff.ctrl[CRMC_CTRL_WAKE]) begin
            // Asleep keeps pass-through; field acts only once awake
            slot_req = crmc_decode_slot(st_ff.ctrl[CRMC_CTRL_MODE_LSB +: 2]);
         end
      end
      // Direct slot swap passes through pass-through for one cycle
      if (st_ff.slot != CRMC_SLOT_NONE && slot_req != CRMC_SLOT_NONE &&
          slot_req != st_ff.slot) begin
         nxt_st.slot = CRMC_SLOT_NONE;
      end else begin
         nxt_st.slot = slot_req;
      end
      // Live conditions
      live = '0;
      live[CRMC_EV_BUSY] = (st_ff.slot != CRMC_SLOT_NONE);
      live[CRMC_EV_VBUS] = vbus_s;
      live[CRMC_EV_VSD] = vsd_s;
      live[CRMC_EV_VTM] = vtm_s;
      live[CRMC_EV_SUSP] = susp_s;
      live[CRMC_EV_FS] = conn_s;
      case (st_ff.slot)
         CRMC_SLOT_ONE: live[CRMC_EV_CARD] = cp1_s;
         CRMC_SLOT_TWO: live[CRMC_EV_CARD] = cp2_s;
         default: live[CRMC_EV_CARD] = 1'b0;
      endcase
      nxt_st.live_prev = live;
      events = live ^ st_ff.live_prev;
      // Card changes caused by leaving reader mode are not card events; entering with a card present raises one
      if (st_ff.slot == CRMC_SLOT_NONE || nxt_st.slot != st_ff.slot) begin
         events[CRMC_EV_CARD] = 1'b0;
      end
      // Read clears; a same-cycle event still sets
      if (hit_irq_lo) begin
         nxt_st.irq_lo = '0;
      end
      nxt_st.irq_lo = nxt_st.irq_lo | events;
      // Read data, registered one cycle after the strobe
      if (reg_rd) begin
         case (reg_addr)
            CRMC_ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
            CRMC_ADDR_CFG1: nxt_st.rdata = st_ff.cfg1;
            CRMC_ADDR_CFG2: nxt_st.rdata = st_ff.cfg2;
            CRMC_ADDR_CFG3: nxt_st.rdata = st_ff.cfg3;
            CRMC_ADDR_IE_LO: nxt_st.rdata = st_ff.ie_lo;
            CRMC_ADDR_IE_HI: nxt_st.rdata = st_ff.ie_hi;
            CRMC_ADDR_IRQ_LO: nxt_st.rdata = {1'b0, st_ff.irq_lo};
            CRMC_ADDR_STAT: nxt_st.rdata = {1'b0, live};
            default: nxt_st.rdata = CRMC_ZERO_RESET;
         endcase
      end
      // Interrupt hold: new enabled event wins over any clear
      if (|(events & st_ff.ie_lo[CRMC_NUM_EV-1:0])) begin
         nxt_st.irq_hold = 1'b1;
         nxt_st.pulse_cnt = CW'(IRQ_PULSE_CYCLES - 1);
      end else if (st_ff.irq_hold) begin
         if (st_ff.cfg1[CRMC_CFG1_PULSE]) begin
            if (st_ff.pulse_cnt == '0) begin
               nxt_st.irq_hold = 1'b0;
            end else begin
               nxt_st.pulse_cnt = st_ff.pulse_cnt - CW'(1);
            end
         end else if (hit_stat) begin
            nxt_st.irq_hold = 1'b0;
         end
      end
      // Shared pin
      if (st_ff.scheme_i2c) begin
         nxt_st.int_oe = st_ff.ctrl[CRMC_CTRL_WAKE];
         nxt_st.int_out = st_ff.cfg1[CRMC_CFG1_ACTHI] ? st_ff.irq_hold
                                                       : ~st_ff.irq_hold;
         nxt_st.clk_src = st_ff.cfg2[CRMC_CLKSRC_W-1:0];
      end else begin
         // Error output: low on reader fault or missing supply in reader mode, mode unchanged
         nxt_st.int_oe = 1'b1;
         nxt_st.int_out = ~((st_ff.slot != CRMC_SLOT_NONE) &&
                            (err_s || !vbus_s || !vsd_s || !vtm_s));
         nxt_st.clk_src = CRMC_CLKSRC_DEFAULT;
      end
      nxt_st.busy_n = (nxt_st.slot == CRMC_SLOT_NONE);
      nxt_st.logic_on = nxt_st.scheme_i2c ? nxt_st.ctrl[CRMC_CTRL_WAKE] : !nxt_st.busy_n;
      // Attached slot's switch bit is ignored and its host switches stay open
      nxt_st.sw1 = nxt_st.ctrl[CRMC_CTRL_SW1] && (nxt_st.slot != CRMC_SLOT_ONE);
      nxt_st.sw2 = nxt_st.ctrl[CRMC_CTRL_SW2] && (nxt_st.slot != CRMC_SLOT_TWO);
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_ff <= '0;
         st_ff.ctrl <= CRMC_CTRL_RESET;
         st_ff.busy_n <= 1'b1;
         st_ff.int_out <= 1'b1;
         st_ff.sw1 <= 1'b1;
         st_ff.sw2 <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata_ff = st_ff.rdata;
   assign busy_n_ff = st_ff.busy_n;
   assign err_irq_ff = st_ff.int_out;
   assign err_irq_oe_ff = st_ff.int_oe;
   assign slot1_sw_ff = st_ff.sw1;
   assign slot2_sw_ff = st_ff.sw2;
   assign reader_slot_ff = st_ff.slot;
   assign logic_on_ff = st_ff.logic_on;
   assign clk_src_ff = st_ff.clk_src;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_sync_b);

   sequence s_gap;
      reader_slot_ff == CRMC_SLOT_NONE;
   endsequence
   sequence s_back;
      busy_n_ff == 1'b1 ##1 busy_n_ff == 1'b0;
   endsequence

   property p_busy_flag;
      hit_stat |=> reg_rdata_ff[CRMC_EV_BUSY] == !$past(busy_n_ff);
   endproperty
   a_busy_flag: assert property (p_busy_flag) else $error("busy flag mismatch");

   property p_strap_fixed;
      st_ff.strap_done && $past(st_ff.strap_done) |-> $stable(st_ff.scheme_i2c);
   endproperty
   a_strap_fixed: assert property (p_strap_fixed) else $error("scheme changed");

   property p_sleep_pass;
      st_ff.scheme_i2c && !st_ff.ctrl[CRMC_CTRL_WAKE] |=> reader_slot_ff == CRMC_SLOT_NONE;
   endproperty
   a_sleep_pass: assert property (p_sleep_pass) else $error("reader while asleep");

   property p_int_float;
      st_ff.scheme_i2c && !st_ff.ctrl[CRMC_CTRL_WAKE] |=> !err_irq_oe_ff;
   endproperty
   a_int_float: assert property (p_int_float) else $error("irq driven asleep");

   property p_read_clear;
      hit_irq_lo && events == '0 |=> st_ff.irq_lo == '0;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("request not cleared");

   property p_attached_open;
      reader_slot_ff == CRMC_SLOT_ONE |-> !slot1_sw_ff;
   endproperty
   a_attached_open: assert property (p_attached_open) else $error("slot 1 switch closed");

   property p_swap;
      reader_slot_ff != CRMC_SLOT_NONE && slot_req != CRMC_SLOT_NONE &&
         slot_req != reader_slot_ff |=> s_gap ##0 s_back;
   endproperty
   a_swap: assert property (p_swap) else $error("no busy gap on swap");

   property p_pulse_len;
      $rose(st_ff.irq_hold) && st_ff.cfg1[CRMC_CFG1_PULSE] |-> st_ff.irq_hold [*8];
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse too short");

   property p_simple_mode;
      st_ff.strap_done && !st_ff.scheme_i2c && mode_s && reader_slot_ff == CRMC_SLOT_NONE
         |=> reader_slot_ff == CRMC_SLOT_ONE && !busy_n_ff;
   endproperty
   a_simple_mode: assert property (p_simple_mode) else $error("mode pin not followed");

   property p_card_pass;
      reader_slot_ff == CRMC_SLOT_NONE && !st_ff.irq_lo[CRMC_EV_CARD] && !hit_irq_lo
         |=> !st_ff.irq_lo[CRMC_EV_CARD];
   endproperty
   a_card_pass: assert property (p_card_pass) else $error("card event in pass-through");

   property p_bridge_error_n;
      !st_ff.scheme_i2c && reader_slot_ff != CRMC_SLOT_NONE && err_s && mode_s
         |=> !err_irq_ff ##0 reader_slot_ff != CRMC_SLOT_NONE;
   endproperty
   a_bridge_error_n: assert property (p_bridge_error_n) else $error("error output not low");
endmodule : crmc_top

/* bench/crmc_host_model.sv */
// Purpose: Host processor model driving scheme pins and the byte register port
// Assumes: One-cycle strobes, read data valid the cycle after the strobe
// Notes: Idle address and data lines show the inverse of the last value
`timescale 1ns/100ps
module crmc_host_model
   import crmc_pkg::*;
(
   input wire logic core_clk,
   output logic scheme_sel_pin,
   output logic mode_pin,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_ff,
   input wire logic err_irq_ff,
   input wire logic busy_n_ff
);
   initial begin
      scheme_sel_pin = 1'b1;
      mode_pin = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   task automatic pins(input logic s, input logic m);
      @(posedge core_clk);
      scheme_sel_pin <= s;
      mode_pin <= m;
   endtask : pins

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= (a == CRMC_ADDR_CTRL) ? {3'b000, d[4:0]} : d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge core_clk);
      d = reg_rdata_ff;
   endtask : rd

   // Enumeration may be slow, so completion is seen on busy, never assumed
   task automatic wait_busy(input logic v, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         @(negedge core_clk);
         ok = (busy_n_ff === v);
      end
   endtask : wait_busy

   task automatic recover();
      @(posedge core_clk);
      if (err_irq_ff === 1'b0) begin
         mode_pin <= 1'b0;
      end
   endtask : recover
endmodule : crmc_host_model

/* bench/card_reader_mode_control_bench.sv */
// Purpose: Self-checking bench for the card reader mode control block
// Assumes: Host model owns scheme, mode and register port
// Notes: Serial control runs first; a second reset selects simple control
`timescale 1ns/100ps
module card_reader_mode_control_bench
   import crmc_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] ev = 5'h1f;
   logic card_pres = 1'b0;
   logic reader_error = 1'b0;
   logic scheme, mode, reg_wr, reg_rd, busy_n, err_irq, err_oe, sw1, sw2, on, ok, seen;
   logic [7:0] reg_addr, reg_wdata, rdata, d;
   logic [1:0] slot;
   logic [4:0] clk_src;
   int n_mismatch = 0;
   int comparisons = 0;

   always #50 core_clk = ~core_clk;

   // Short pulse keeps the timed interrupt case brief
   crmc_top #(.IRQ_PULSE_CYCLES(16)) i_crmc_top (
      .core_clk(core_clk), .rst_b(rst_b), .scheme_sel_pin(scheme), .mode_pin(mode),
      .usb_connected(ev[4]), .usb_suspended(ev[3]), .bus_power_sense(ev[0]),
      .card_supply(ev[1]), .transceiver_supply(ev[2]), .card_present_line(card_pres),
      .card2_present(card_pres), .reader_error(reader_error), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(rdata),
      .busy_n_ff(busy_n), .err_irq_ff(err_irq), .err_irq_oe_ff(err_oe),
      .slot1_sw_ff(sw1), .slot2_sw_ff(sw2), .reader_slot_ff(slot),
      .logic_on_ff(on), .clk_src_ff(clk_src)
   );

   crmc_host_model i_crmc_host_model (
      .core_clk(core_clk), .scheme_sel_pin(scheme), .mode_pin(mode),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata_ff(rdata), .err_irq_ff(err_irq), .busy_n_ff(busy_n)
   );

   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk8

   task automatic chk1(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %b seen %b", n, e, g);
      end
   endtask : chk1

   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : settle

   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      i_crmc_host_model.rd(a, d);
      chk8("register", e, d);
   endtask : rreg

   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      i_crmc_host_model.wr(a, v);
      settle(4);
   endtask : wreg

   task automatic do_reset(input logic s);
      i_crmc_host_model.pins(s, 1'b0);
      rst_b <= 1'b0;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      settle(12);
   endtask : do_reset

   task automatic t_reset_values();
      rreg(CRMC_ADDR_CTRL, CRMC_CTRL_RESET);
      rreg(CRMC_ADDR_CFG1, 8'h00);
      rreg(CRMC_ADDR_IE_LO, 8'h00);
      rreg(8'h07, 8'h00);
      chk1("busy_n", 1'b1, busy_n);
      chk1("sw1", 1'b1, sw1);
      chk1("sw2", 1'b1, sw2);
      chk1("irq_oe", 1'b0, err_oe);
      chk1("logic_on", 1'b0, on);
   endtask : t_reset_values

   task automatic t_reader();
      wreg(CRMC_ADDR_CTRL, 8'heb);
      rreg(CRMC_ADDR_CTRL, 8'h0b);
      chk8("slot", 8'h01, {6'h00, slot});
      chk1("busy_n", 1'b0, busy_n);
      chk1("sw1", 1'b0, sw1);
      chk1("sw2", 1'b0, sw2);
      chk1("logic_on", 1'b1, on);
      i_crmc_host_model.rd(CRMC_ADDR_STAT, d);
      chk1("busy_flag", 1'b1, d[CRMC_EV_BUSY]);
      wreg(CRMC_ADDR_CTRL, 8'h1b);
      chk1("sw2", 1'b1, sw2);
      wreg(CRMC_ADDR_CTRL, 8'h14);
      chk8("slot", 8'h00, {6'h00, slot});
      chk1("busy_n", 1'b1, busy_n);
      chk1("logic_on", 1'b0, on);
      i_crmc_host_model.rd(CRMC_ADDR_STAT, d);
      chk1("busy_flag", 1'b0, d[CRMC_EV_BUSY]);
      wreg(CRMC_ADDR_CTRL, 8'h15);
      chk8("slot", 8'h02, {6'h00, slot});
   endtask : t_reader

   // Moving the reader to the other slot must show a gap on busy
   task automatic t_swap();
      i_crmc_host_model.wr(CRMC_ADDR_CTRL, 8'h13);
      seen = 1'b0;
      repeat (6) begin
         @(negedge core_clk);
         if (slot === 2'b00 && busy_n === 1'b1) seen = 1'b1;
      end
      chk1("swap_gap", 1'b1, seen);
      chk8("slot", 8'h01, {6'h00, slot});
      wreg(CRMC_ADDR_CTRL, 8'h17);
      chk8("slot", 8'h00, {6'h00, slot});
   endtask : t_swap

   task automatic t_events();
      i_crmc_host_model.rd(CRMC_ADDR_IRQ_LO, d);
      for (int k = 0; k < 5; k++) begin
         @(posedge core_clk) ev[k] <= ~ev[k];
         settle(10);
         chk1("masked_pin", 1'b1, err_irq);
         rreg(CRMC_ADDR_IRQ_LO, 8'h04 << k);
         rreg(CRMC_ADDR_IRQ_LO, 8'h00);
         i_crmc_host_model.rd(CRMC_ADDR_STAT, d);
         chk1("live", 1'b0, d[k+2]);
         @(posedge core_clk) ev[k] <= ~ev[k];
         settle(10);
         rreg(CRMC_ADDR_IRQ_LO, 8'h04 << k);
      end
   endtask : t_events

   // Card line moves count only while its slot is attached
   task automatic t_card();
      @(posedge core_clk) card_pres <= 1'b1;
      settle(10);
      rreg(CRMC_ADDR_IRQ_LO, 8'h00);
      wreg(CRMC_ADDR_CTRL, 8'h13);
      i_crmc_host_model.rd(CRMC_ADDR_IRQ_LO, d);
      @(posedge core_clk) card_pres <= 1'b0;
      settle(10);
      rreg(CRMC_ADDR_IRQ_LO, 8'h01);
      wreg(CRMC_ADDR_CTRL, 8'h17);
      i_crmc_host_model.rd(CRMC_ADDR_IRQ_LO, d);
      @(posedge core_clk) card_pres <= 1'b1;
      settle(10);
      rreg(CRMC_ADDR_IRQ_LO, 8'h00);
   endtask : t_card

   task automatic t_irq_modes();
      wreg(CRMC_ADDR_IE_LO, 8'h04);
      @(posedge core_clk) ev[0] <= 1'b0;
      settle(10);
      chk1("irq", 1'b0, err_irq);
      i_crmc_host_model.rd(CRMC_ADDR_IRQ_LO, d);
      settle(4);
      chk1("irq", 1'b0, err_irq);
      i_crmc_host_model.rd(CRMC_ADDR_STAT, d);
      settle(2);
      chk1("irq", 1'b1, err_irq);
      wreg(CRMC_ADDR_CFG1, 8'h03);
      @(posedge core_clk) ev[0] <= 1'b1;
      settle(10);
      chk1("irq", 1'b1, err_irq);
      settle(30);
      chk1("irq", 1'b0, err_irq);
      wreg(CRMC_ADDR_CTRL, 8'h16);
      chk1("irq_oe", 1'b0, err_oe);
   endtask : t_irq_modes

   task automatic t_simple();
      do_reset(1'b0);
      // Scheme pin raised after start-up must change nothing
      i_crmc_host_model.pins(1'b1, 1'b1);
      i_crmc_host_model.wait_busy(1'b0, ok);
      chk1("enter", 1'b1, ok);
      chk8("slot", 8'h01, {6'h00, slot});
      chk1("logic_on", 1'b1, on);
      chk8("clk_src", 8'h00, {3'h0, clk_src});
      chk1("err_oe", 1'b1, err_oe);
      chk1("err", 1'b1, err_irq);
      @(posedge core_clk) ev[0] <= 1'b0;
      settle(10);
      chk1("err", 1'b0, err_irq);
      chk8("slot", 8'h01, {6'h00, slot});
      @(posedge core_clk) ev[0] <= 1'b1;
      settle(10);
      chk1("err", 1'b1, err_irq);
      @(posedge core_clk) reader_error <= 1'b1;
      settle(10);
      chk1("err", 1'b0, err_irq);
      i_crmc_host_model.recover();
      i_crmc_host_model.wait_busy(1'b1, ok);
      chk1("leave", 1'b1, ok);
      chk8("slot", 8'h00, {6'h00, slot});
   endtask : t_simple

   initial begin
      do_reset(1'b1);
      t_reset_values();
      t_reader();
      t_swap();
      t_events();
      t_card();
      t_irq_modes();
      t_simple();
      conclude();
   end

   // Whole run needs well under a thousand cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      conclude();
   end
endmodule : card_reader_mode_control_bench
